// *** gclkri_pkg.sv ***
// constants, field layout and reset configuration of the clock controller register block
// assumes an AXI4-Lite master on core_clk and a single 40 MHz clock domain
package gclkri_pkg;
    // register offsets are word indices; byte address is four times the index
    localparam logic [3:0] IDX_TOP_CONTROL = 4'h0;
    localparam logic [3:0] IDX_SYNC_STATUS = 4'h1;
    localparam logic [3:0] IDX_CHANNEL_CONTROL = 4'h2;
    localparam logic [3:0] IDX_GENERATOR_CONTROL = 4'h4;
    localparam logic [3:0] IDX_GENERATOR_DIVISION = 4'h8;
    // field positions
    localparam int SOFT_CLEAR_BIT = 0;
    localparam int PENDING_BIT = 7;
    localparam int CH_FREEZE_BIT = 15;
    localparam int CH_ON_BIT = 14;
    localparam int CH_PICK_LSB = 8;
    localparam int GC_SRC_LSB = 8;
    localparam int GC_FLAG_LSB = 16;
    localparam int GD_DIV_LSB = 8;
    // generator flag bits inside the six-bit flag group
    localparam int GF_ON = 0;
    localparam int GF_OOV = 2;
    localparam int GF_OE = 3;
    localparam int GF_KEEP = 5;
    // counts and reset configuration
    localparam int NUM_CH = 28;
    localparam int NUM_GEN = 8;
    localparam int SYNC_CYCLES = 4;
    localparam int CH_WDT = 1;
    localparam int CH_RTC = 2;
    localparam logic [3:0] WDT_PICK_RST = 4'h2;
    localparam logic WDT_ON_RST = 1'b0;
    localparam logic [7:0] GEN_ON_RST = 8'h01;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // what a synchronized operation will commit when it completes
    typedef enum logic [2:0] {
        PEND_NONE,
        PEND_CLEAR,
        PEND_GCTRL,
        PEND_GDIV,
        PEND_CHON
    } gclkri_pend_t;
endpackage : gclkri_pkg

// *** gclkri_sync_delay.sv ***
// fixed-latency model of the crossing into the generic clock domain
// assumes start is a one-cycle pulse and is not repeated before done
module gclkri_sync_delay #(
    parameter int CYCLES = gclkri_pkg::SYNC_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // handshake
    input wire logic start,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);
    logic [CW-1:0] count;
    logic running;

    // count from start to completion; done pulses one cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                running <= 1'b1;
                count <= CW'(1);
            end else if (running) begin
                if (count == LAST) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count + CW'(1);
                end
            end
        end
    end
endmodule : gclkri_sync_delay

// *** gclkri_top.sv ***
// register interface and clock gating control of the generic clock controller
// assumes AXI4-Lite master, sleep inputs from the power logic, source ready from oscillators
//
// Added by the designer: the AXI4-Lite register port.
module gclkri_top #(
    parameter int NCH = gclkri_pkg::NUM_CH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic usr_rst,
    // axi4-lite write
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [5:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // sleep and peripheral requests
    input wire logic sleep,
    input wire logic standby,
    input wire logic [NCH-1:0] clk_req,
    // clock sources and gating
    input wire logic [7:0] src_ready,
    output logic [7:0] src_wake,
    output logic [7:0] gen_run,
    output logic [NCH-1:0] ch_clk_en,
    // generator clock pins
    output logic [7:0] clock_pin_oe_n,
    output logic [7:0] clock_pin_idle
);
    logic [3:0] ch_pick [NCH];
    logic [NCH-1:0] ch_on;
    logic [NCH-1:0] ch_freeze;
    logic [5:0] gen_flag [8];
    logic [4:0] gen_src [8];
    logic [15:0] gen_div [8];
    logic [7:0] gen_lock;
    logic [5:0] sel_ch;
    logic [3:0] sel_gc;
    logic [3:0] sel_gd;
    logic crossing_pending;
    logic soft_clear;
    gclkri_pkg::gclkri_pend_t pend_kind;
    logic [5:0] pend_id;
    logic [31:0] pend_word;
    logic sync_done;
    logic aw_got;
    logic w_got;
    logic [3:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [7:0] src_meta;
    logic [7:0] src_ok;
    // top bit of the generator pick field, declared ahead of every use
    localparam int CH_PICK_HI = gclkri_pkg::CH_PICK_LSB + 3;

    // merge the strobed byte lanes of a write into the current word
    function automatic logic [31:0] lane_merge(input logic [31:0] cur, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = cur;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // generator pick after power reset, per channel
    function automatic logic [3:0] ch_pick_rst(input int c);
        return (c == gclkri_pkg::CH_WDT) ? gclkri_pkg::WDT_PICK_RST : 4'h0;
    endfunction : ch_pick_rst

    function automatic logic ch_on_rst(input int c);
        return (c == gclkri_pkg::CH_WDT) ? gclkri_pkg::WDT_ON_RST : 1'b0;
    endfunction : ch_on_rst

    // the reserved pick codes and out-of-range ids are filtered here
    function automatic logic gen_valid(input logic [3:0] g);
        return g < 4'h8;
    endfunction : gen_valid

    // generator control word as software sees it
    function automatic logic [31:0] gc_word(input logic [3:0] id, input logic [5:0] f,
                                            input logic [4:0] s);
        return {10'h000, f, 3'h0, s, 4'h0, id};
    endfunction : gc_word

    always_comb begin
        gen_lock = 8'h00;
        for (int c = 0; c < NCH; c++) begin
            if (ch_freeze[c] && gen_valid(ch_pick[c]) && ch_pick[c] != 4'h0) begin
                gen_lock[ch_pick[c][2:0]] = 1'b1;
            end
        end
    end

    // write decode from the captured address and data
    logic wr_go;
    logic hit_top;
    logic hit_ch;
    logic hit_gc;
    logic hit_gd;
    logic [5:0] ch_nid;
    logic ch_ok;
    logic ch_wr;
    logic [3:0] gc_nid;
    logic gc_ok;
    logic gc_wr;
    logic [31:0] gc_new;
    logic [3:0] gd_nid;
    logic gd_ok;
    logic gd_wr;
    logic [31:0] gd_new;
    logic sc_go;
    logic chon_go;
    logic sync_go;
    logic wr_mapped;

    // a write is performed only once no crossing is pending
    assign wr_go = aw_got && w_got && !s_axi_bvalid && !crossing_pending;
    assign hit_top = wa == gclkri_pkg::IDX_TOP_CONTROL;
    assign hit_ch = wa == gclkri_pkg::IDX_CHANNEL_CONTROL;
    assign hit_gc = wa == gclkri_pkg::IDX_GENERATOR_CONTROL;
    assign hit_gd = wa == gclkri_pkg::IDX_GENERATOR_DIVISION;
    assign wr_mapped = hit_top || hit_ch || hit_gc || hit_gd || wa == gclkri_pkg::IDX_SYNC_STATUS;
    // the id lane, when strobed, picks the instance for the other lanes
    assign ch_nid = ws[0] ? wd[5:0] : sel_ch;
    assign ch_ok = ch_nid < 6'(NCH) && !ch_freeze[ch_nid[4:0]];
    assign ch_wr = wr_go && hit_ch && ws[1] && ch_ok;
    assign gc_nid = ws[0] ? wd[3:0] : sel_gc;
    assign gc_ok = gen_valid(gc_nid) && !gen_lock[gc_nid[2:0]];
    assign gc_new = lane_merge(gc_word(gc_nid, gen_flag[gc_nid[2:0]], gen_src[gc_nid[2:0]]),
                               wd, ws);
    assign gc_wr = wr_go && hit_gc && (|ws[3:1]) && gc_ok;
    assign gd_nid = ws[0] ? wd[3:0] : sel_gd;
    assign gd_ok = gen_valid(gd_nid) && !gen_lock[gd_nid[2:0]];
    assign gd_new = lane_merge({8'h00, gen_div[gd_nid[2:0]], 4'h0, gd_nid}, wd, ws);
    assign gd_wr = wr_go && hit_gd && (|ws[3:1]) && gd_ok;
    // only a one in the soft_clear bit starts anything
    assign sc_go = wr_go && hit_top && ws[0] && wd[gclkri_pkg::SOFT_CLEAR_BIT];
    assign chon_go = ch_wr && (wd[gclkri_pkg::CH_ON_BIT] != ch_on[ch_nid[4:0]]);
    assign sync_go = sc_go || chon_go || gc_wr || gd_wr;

    logic sc_commit;
    assign sc_commit = sync_done && pend_kind == gclkri_pkg::PEND_CLEAR;

    gclkri_sync_delay #(
        .CYCLES(gclkri_pkg::SYNC_CYCLES)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .start(sync_go),
        .done(sync_done)
    );

    // pending flag and staged payload of the running crossing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            crossing_pending <= 1'b0;
            soft_clear <= 1'b0;
            pend_kind <= gclkri_pkg::PEND_NONE;
            pend_id <= 6'h00;
            pend_word <= 32'h0000_0000;
        end else if (ce) begin
            if (sync_go) begin
                crossing_pending <= 1'b1;
                soft_clear <= sc_go;
                pend_id <= hit_ch ? ch_nid : (hit_gc ? {2'b00, gc_nid} : {2'b00, gd_nid});
                pend_word <= hit_gc ? gc_new : (hit_gd ? gd_new : wd);
                if (sc_go) begin
                    pend_kind <= gclkri_pkg::PEND_CLEAR;
                end else if (gc_wr) begin
                    pend_kind <= gclkri_pkg::PEND_GCTRL;
                end else if (gd_wr) begin
                    pend_kind <= gclkri_pkg::PEND_GDIV;
                end else begin
                    pend_kind <= gclkri_pkg::PEND_CHON;
                end
            end else if (sync_done) begin
                // both flags drop together at completion
                crossing_pending <= 1'b0;
                soft_clear <= 1'b0;
                pend_kind <= gclkri_pkg::PEND_NONE;
            end
        end
    end

    // channel registers; freeze clears only on power reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                ch_pick[c] <= ch_pick_rst(c);
                ch_on[c] <= ch_on_rst(c);
                ch_freeze[c] <= 1'b0;
            end
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                if (!ch_freeze[c] && (sc_commit || (usr_rst && c != gclkri_pkg::CH_RTC))) begin
                    ch_pick[c] <= ch_pick_rst(c);
                    ch_on[c] <= ch_on_rst(c);
                end
            end
            if (ch_wr) begin
                // reserved pick codes leave the field unchanged
                if (gen_valid(wd[CH_PICK_HI:gclkri_pkg::CH_PICK_LSB])) begin
                    ch_pick[ch_nid[4:0]] <= wd[CH_PICK_HI:gclkri_pkg::CH_PICK_LSB];
                end
                // writing the freeze bit locks the channel
                if (wd[gclkri_pkg::CH_FREEZE_BIT]) begin
                    ch_freeze[ch_nid[4:0]] <= 1'b1;
                end
            end
            // on/off takes effect only at completion
            if (sync_done && pend_kind == gclkri_pkg::PEND_CHON) begin
                ch_on[pend_id[4:0]] <= pend_word[gclkri_pkg::CH_ON_BIT];
            end
        end
    end

    // generator control and division
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int g = 0; g < 8; g++) begin
                gen_flag[g] <= {5'h00, gclkri_pkg::GEN_ON_RST[g]};
                gen_src[g] <= 5'h00;
                gen_div[g] <= 16'h0000;
            end
        end else if (ce) begin
            for (int g = 0; g < 8; g++) begin
                // locked generators survive soft and user resets
                if (!gen_lock[g] && (sc_commit || usr_rst)) begin
                    gen_flag[g] <= {5'h00, gclkri_pkg::GEN_ON_RST[g]};
                    gen_src[g] <= 5'h00;
                    gen_div[g] <= 16'h0000;
                end
            end
            // staged generator writes land after the crossing
            if (sync_done && pend_kind == gclkri_pkg::PEND_GCTRL) begin
                gen_flag[pend_id[2:0]] <= pend_word[gclkri_pkg::GC_FLAG_LSB +: 6];
                gen_src[pend_id[2:0]] <= pend_word[gclkri_pkg::GC_SRC_LSB +: 5];
            end
            if (sync_done && pend_kind == gclkri_pkg::PEND_GDIV) begin
                gen_div[pend_id[2:0]] <= pend_word[gclkri_pkg::GD_DIV_LSB +: 16];
            end
        end
    end

    // instance selectors follow id lane writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_ch <= 6'h00;
            sel_gc <= 4'h0;
            sel_gd <= 4'h0;
        end else if (ce) begin
            if (sc_commit) begin
                sel_ch <= 6'h00;
                sel_gc <= 4'h0;
                sel_gd <= 4'h0;
            end
            if (wr_go && ws[0] && hit_ch) begin
                sel_ch <= wd[5:0];
            end
            if (wr_go && ws[0] && hit_gc) begin
                sel_gc <= wd[3:0];
            end
            if (wr_go && ws[0] && hit_gd) begin
                sel_gd <= wd[3:0];
            end
        end
    end

    // axi write channels; address and data are taken in either order
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gclkri_pkg::RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wa <= 4'h0;
            wd <= 32'h0000_0000;
            ws <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                s_axi_awready <= 1'b0;
                wa <= s_axi_awaddr[5:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                s_axi_wready <= 1'b0;
                wd <= s_axi_wdata;
                ws <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? gclkri_pkg::RESP_OKAY : gclkri_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read mux; reads are never stalled, only writes cross domains
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr[5:2])
            gclkri_pkg::IDX_TOP_CONTROL: rd_word[gclkri_pkg::SOFT_CLEAR_BIT] = soft_clear;
            gclkri_pkg::IDX_SYNC_STATUS: rd_word[gclkri_pkg::PENDING_BIT] = crossing_pending;
            gclkri_pkg::IDX_CHANNEL_CONTROL: begin
                rd_word[5:0] = sel_ch;
                if (sel_ch < 6'(NCH)) begin
                    rd_word[gclkri_pkg::CH_FREEZE_BIT] = ch_freeze[sel_ch[4:0]];
                    rd_word[gclkri_pkg::CH_ON_BIT] = ch_on[sel_ch[4:0]];
                    rd_word[CH_PICK_HI:gclkri_pkg::CH_PICK_LSB] = ch_pick[sel_ch[4:0]];
                end
            end
            gclkri_pkg::IDX_GENERATOR_CONTROL: begin
                rd_word = gc_word(sel_gc, gen_valid(sel_gc) ? gen_flag[sel_gc[2:0]] : 6'h00,
                                  gen_valid(sel_gc) ? gen_src[sel_gc[2:0]] : 5'h00);
            end
            gclkri_pkg::IDX_GENERATOR_DIVISION: begin
                rd_word[3:0] = sel_gd;
                if (gen_valid(sel_gd)) begin
                    rd_word[gclkri_pkg::GD_DIV_LSB +: 16] = gen_div[sel_gd[2:0]];
                end
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // axi read channel, one cycle from address to data
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= gclkri_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? gclkri_pkg::RESP_OKAY : gclkri_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // source ready comes from oscillator logic, so it is synchronised first
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            src_meta <= 8'h00;
            src_ok <= 8'h00;
        end else if (ce) begin
            src_meta <= src_ready;
            src_ok <= src_meta;
        end
    end

    // generator demand: free running when awake, on request in sleep
    logic [7:0] gen_need;
    always_comb begin
        gen_need = 8'h00;
        for (int c = 0; c < NCH; c++) begin
            // a requesting enabled channel pulls its generator
            if (ch_on[c] && gen_valid(ch_pick[c]) && (!sleep || clk_req[c])) begin
                gen_need[ch_pick[c][2:0]] = 1'b1;
            end
        end
        for (int g = 0; g < 8; g++) begin
            // keep-alive holds a pin-routed generator in sleep
            if (!sleep || (gen_flag[g][gclkri_pkg::GF_OE] &&
                           gen_flag[g][gclkri_pkg::GF_KEEP])) begin
                gen_need[g] = 1'b1;
            end
            gen_need[g] = gen_need[g] && gen_flag[g][gclkri_pkg::GF_ON];
        end
    end

    // wake source, then generator three cycles after its src_ready rises, then channel one cycle later
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            src_wake <= 8'h00;
            gen_run <= 8'h00;
            ch_clk_en <= '0;
        end else if (ce) begin
            src_wake <= gen_need;
            gen_run <= gen_need & src_ok;
            for (int c = 0; c < NCH; c++) begin
                ch_clk_en[c] <= ch_on[c] && gen_valid(ch_pick[c]) && gen_run[ch_pick[c][2:0]] &&
                                (!sleep || clk_req[c]);
            end
        end
    end

    // pin carries the generator clock; otherwise it rests at the idle level
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clock_pin_oe_n <= 8'hFF;
            clock_pin_idle <= 8'h00;
        end else if (ce) begin
            for (int g = 0; g < 8; g++) begin
                clock_pin_oe_n[g] <= !(gen_flag[g][gclkri_pkg::GF_OE] && gen_run[g] &&
                                       (!standby || gen_flag[g][gclkri_pkg::GF_KEEP]));
                clock_pin_idle[g] <= gen_flag[g][gclkri_pkg::GF_OOV];
            end
        end
    end
endmodule : gclkri_top

// *** gclkri_src_model.sv ***
// stand-in for the clock sources behind each generator
// assumes wake requests come from the controller on core_clk
module gclkri_src_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // wake and ready per generator
    input wire logic [7:0] src_wake,
    output logic [7:0] src_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ready lags wake by a cycle; a dropped wake stops the source one cycle later
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) src_ready <= 8'h00;
        else src_ready <= src_wake;
    end
endmodule : gclkri_src_model

// *** gclkri_top_sva.sv ***
// handshake checks on the register port of the clock controller
// assumes it is bound into gclkri_top and sees only its ports
module gclkri_top_sva (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    // a low enable freezes all state, so checks pause with it
    default disable iff (rst || !ce);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    a_r_prompt: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_rearm: assert property ($rose(s_axi_arready) |-> $past(s_axi_rvalid))
        else $error("read address reopened early");
    a_aw_low: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address still open");
    a_b_late: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
        else $error("write answer before both taken");
    a_b_due: assert property (
        $fell(s_axi_wready) && !s_axi_awready |-> ##[1:8] s_axi_bvalid)
        else $error("write stalled too long");
    a_rd_idle: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open during answer");
endmodule : gclkri_top_sva
bind gclkri_top gclkri_top_sva i_gclkri_top_sva (.*);

// *** generic_clock_register_interface_bench.sv ***
// self-checking bench of the clock controller register port
// assumes the source model on the far side and ce held high
module generic_clock_register_interface_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst, ce, usr_rst, sleep, standby, s_axi_bvalid, s_axi_bready, s_axi_rvalid;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rready;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [27:0] clk_req, ch_clk_en;
    logic [7:0] src_ready, src_wake, gen_run, clock_pin_oe_n, clock_pin_idle;
    int fail_count = 0;
    int checks_done = 0;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %0t got %h want %h", $time, g, e); end end
    gclkri_top i_gclkri_top (.*);
    gclkri_src_model i_gclkri_src_model (.*);
    // 40 MHz core clock
    initial forever #12.5 core_clk = ~core_clk;
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] e = 2'h0);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, e)
    endtask : wr
    // read one word and compare it
    task automatic rc(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, r)
    endtask : rc
    // verdict and end of run
    task automatic wrap_up;
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // the tests need well under a thousand cycles; a hang ends here
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        {rst, ce, usr_rst, sleep, standby, clk_req} = {2'h3, 31'h0};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 48'h0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        wr(6'h08, 32'h01, 4'h1);
        rc(6'h08, 32'h0201);
        wr(6'h10, 32'h00, 4'h1);
        rc(6'h10, 32'h00010000);
        wr(6'h20, 32'h00123403, 4'hF);
        rc(6'h04, 32'h80);
        wr(6'h10, 32'h002D0003, 4'hF);
        wr(6'h20, 32'h00770002, 4'h5);
        repeat (8) @(posedge core_clk);
        rc(6'h20, 32'h00770002);
        wr(6'h20, 32'h03, 4'h1);
        rc(6'h20, 32'h00123403);
        wr(6'h08, 32'h4305, 4'h3);
        rc(6'h08, 32'h0305);
        repeat (8) @(posedge core_clk);
        rc(6'h08, 32'h4305);
        {sleep, standby} <= 2'h3;
        repeat (6) @(posedge core_clk);
        `CHK({ch_clk_en[5], src_wake, gen_run}, 17'h00808)
        clk_req[5] <= 1'b1;
        repeat (6) @(posedge core_clk);
        `CHK({ch_clk_en[5], src_wake, gen_run}, 17'h10808)
        `CHK(clock_pin_oe_n, 8'hF7)
        `CHK(clock_pin_idle, 8'h08)
        {sleep, standby, clk_req[5]} <= 3'h0;
        wr(6'h00, 32'h00, 4'h1);
        rc(6'h00, 32'h00);
        wr(6'h08, 32'hC305, 4'h3);
        wr(6'h20, 32'h00FF0003, 4'hF);
        repeat (8) @(posedge core_clk);
        rc(6'h20, 32'h00123403);
        wr(6'h08, 32'h8006, 4'h3);
        wr(6'h20, 32'h00000700, 4'hF);
        wr(6'h08, 32'h0807, 4'h3);
        rc(6'h08, 32'h0007);
        rc(6'h20, 32'h0700);
        wr(6'h00, 32'h01, 4'h1);
        rc(6'h00, 32'h01);
        repeat (8) @(posedge core_clk);
        rc(6'h04, 32'h00);
        wr(6'h20, 32'h02, 4'h1);
        rc(6'h20, 32'h02);
        wr(6'h08, 32'h05, 4'h1);
        rc(6'h08, 32'hC305);
        wr(6'h0C, 32'h01, 4'hF, 2'h2);
        rc(6'h0C, 32'h00, 2'h2);
        wr(6'h08, 32'h0107, 4'h3);
        wr(6'h08, 32'h0102, 4'h3);
        usr_rst <= 1'b1;
        @(posedge core_clk);
        usr_rst <= 1'b0;
        rc(6'h08, 32'h0102);
        wr(6'h08, 32'h07, 4'h1);
        rc(6'h08, 32'h0007);
        wrap_up();
    end
endmodule : generic_clock_register_interface_bench
